// file: uri_far_uart.sv
`timescale 1ns/10ps
module uri_far_uart #(
	parameter int DIV = 16
) (
	input  wire logic ref_clk_in,
	input  wire logic line_in,
	output logic      line_out,
	output logic      cts_n_out
);
	// Both lines idle high, as with a pull-up.
	initial {line_out, cts_n_out} = 2'b11;
	// Start, data LSB first, even parity, stop, one idle bit.
	task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
		logic [11:0] f;
		f = {1'b1, ~bad_stop, ^b ^ bad_par, b, 1'b0};
		for (int i = 0; i < 12; i++) begin
			line_out <= f[i];
			repeat (DIV) @(posedge ref_clk_in);
		end
	endtask : send
	// Samples each data bit at its middle.
	task automatic get(output logic [7:0] b);
		@(negedge line_in);
		repeat (DIV + DIV / 2) @(posedge ref_clk_in);
		for (int i = 0; i < 8; i++) begin
			b[i] = line_in;
			repeat (DIV) @(posedge ref_clk_in);
		end
	endtask : get
endmodule : uri_far_uart

// file: uri_pkg.sv
package uri_pkg;
	// Transmitter sequencer, one-hot.
	typedef enum logic [4:0] {
		URI_TX_IDLE  = 5'h01,
		URI_TX_START = 5'h02,
		URI_TX_DATA  = 5'h04,
		URI_TX_PAR   = 5'h08,
		URI_TX_STOP  = 5'h10
	} uri_tx_st_t;
	// Receiver sequencer, one-hot.
	typedef enum logic [4:0] {
		URI_RX_IDLE  = 5'h01,
		URI_RX_START = 5'h02,
		URI_RX_DATA  = 5'h04,
		URI_RX_PAR   = 5'h08,
		URI_RX_STOP  = 5'h10
	} uri_rx_st_t;
	// Frame configuration, laid out as the config register bits 4..0.
	typedef struct packed {
		logic       stop2;
		logic [2:0] parity;
		logic       hw_flow_control_enable;
	} uri_cfg_t;
	// Event flags, one bit per event register.
	typedef struct packed {
		logic receiver_timeout;
		logic err;
		logic txrdy;
		logic rxrdy;
		logic ncts;
		logic cts;
	} uri_evt_t;
	// Sticky receive error sources, laid out as error register bits 3..0.
	typedef struct packed {
		logic brk;
		logic framing;
		logic parity;
		logic overrun;
	} uri_err_t;
endpackage : uri_pkg

// file: uri_regs.svh
`ifndef URI_REGS_SVH
`define URI_REGS_SVH
`define URI_BASE         32'h40002000
`define URI_BASE_MASK    32'hfffff000
`define URI_OFF_START_RX 12'h000
`define URI_OFF_STOP_RX  12'h004
`define URI_OFF_START_TX 12'h008
`define URI_OFF_STOP_TX  12'h00c
`define URI_OFF_SUSPEND  12'h01c
`define URI_OFF_EV_CTS   12'h100
`define URI_OFF_EV_NCTS  12'h104
`define URI_OFF_EV_RXRDY 12'h108
`define URI_OFF_EV_TXRDY 12'h11c
`define URI_OFF_EV_ERR   12'h124
`define URI_OFF_EV_RECEIVER_TIMEOUT  12'h144
`define URI_OFF_EVENT_TASK_SHORTCUTS   12'h200
`define URI_OFF_IRQ_ENABLE_SET 12'h304
`define URI_OFF_IRQ_ENABLE_CLEAR 12'h308
`define URI_OFF_ERRSRC   12'h480
`define URI_OFF_ENABLE   12'h500
`define URI_OFF_PSEL0    12'h508
`define URI_OFF_PSEL1    12'h50c
`define URI_OFF_PSEL2    12'h510
`define URI_OFF_PSEL3    12'h514
`define URI_OFF_RXD      12'h518
`define URI_OFF_TXD      12'h51c
`define URI_OFF_BAUD     12'h524
`define URI_OFF_CONFIG   12'h56c
`define URI_SH_CTS_BIT   3
`define URI_SH_NCTS_BIT  4
`define URI_IE_CTS       0
`define URI_IE_NCTS      1
`define URI_IE_RXRDY     2
`define URI_IE_TXRDY     7
`define URI_IE_ERR       9
`define URI_IE_RECEIVER_TIMEOUT      17
`define URI_ENABLE_ON    4'h4
`define URI_PARITY_ON    3'h7
`define URI_PSEL_RST     32'hffffffff
`define URI_BAUD_RST     32'h000006c8
`define URI_DIV_MIN      16'h0010
`define URI_FIFO_DEPTH   6
`define URI_RTS_SPACE    4
`define URI_FRAME_NOPAR  20'h0000a
`define URI_FRAME_PAR    20'h0000b
`define URI_RECEIVER_TIMEOUT_BITS    8'h32
`endif

// file: uri_uart.sv
`timescale 1ns/10ps
`include "uri_regs.svh"
module uri_uart import uri_pkg::*; #(
	parameter int FIFO_DEPTH = `URI_FIFO_DEPTH
) (
	input  wire logic        ref_clk_in,
	input  wire logic        srst_in,
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	input  wire logic        rxd_in,
	input  wire logic        cts_n_in,
	output logic      [31:0] rdata_out,
	output logic             txd_out,
	output logic             rts_n_out,
	output logic             irq_out
);
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam logic [PW:0] DEPTH_C = (PW+1)'(FIFO_DEPTH);
	localparam logic [PW:0] RTS_LVL = (PW+1)'(FIFO_DEPTH - `URI_RTS_SPACE);

	////////////////////////////////////////////////////////////////////////
	// Register state and decode.
	logic [3:0]  enable_ff;              // Unit enable field.
	uri_cfg_t    cfg_ff;                 // Frame configuration.
	logic [31:0] baud_ff;                // Bit period in clock cycles, low half.
	logic [1:0]  event_task_shortcuts_ff;              // Bit 0 CTS start, bit 1 NCTS stop.
	logic [31:0] psel_ff [4];            // Pin selects, storage only.
	uri_evt_t    evt_ff;                 // Sticky event registers.
	logic [5:0]  inten_ff;               // Interrupt enables.
	uri_err_t    err_ff;                 // Sticky error sources.
	logic        hit;                    // Address lies in this block.
	logic [11:0] off;                    // Offset within the block.
	logic        unit_on;                // Unit enabled.
	logic [15:0] div;                    // Clamped bit period.

	assign hit     = (addr_in & `URI_BASE_MASK) == `URI_BASE;
	assign off     = addr_in[11:0];
	assign unit_on = enable_ff == `URI_ENABLE_ON;
	assign div     = (baud_ff[15:0] < `URI_DIV_MIN) ? `URI_DIV_MIN : baud_ff[15:0];

	// One-cycle trigger: write of 1 to a task offset.
	function automatic logic trig(input logic [11:0] o);
		trig = wr_in && hit && (off == o) && wdata_in[0];
	endfunction : trig

	// Gather interrupt bits from their word positions.
	function automatic logic [5:0] ie_pack(input logic [31:0] w);
		ie_pack = {w[`URI_IE_RECEIVER_TIMEOUT], w[`URI_IE_ERR], w[`URI_IE_TXRDY],
			w[`URI_IE_RXRDY], w[`URI_IE_NCTS], w[`URI_IE_CTS]};
	endfunction : ie_pack

	// Scatter interrupt bits back to their word positions.
	function automatic logic [31:0] ie_unpack(input logic [5:0] v);
		logic [31:0] w;
		w = 32'h0;
		{w[`URI_IE_RECEIVER_TIMEOUT], w[`URI_IE_ERR], w[`URI_IE_TXRDY]} = v[5:3];
		{w[`URI_IE_RXRDY], w[`URI_IE_NCTS], w[`URI_IE_CTS]} = v[2:0];
		ie_unpack = w;
	endfunction : ie_unpack

	// Offset of each event register, indexed as in uri_evt_t.
	function automatic logic [11:0] evt_off(input int i);
		case (i)
			0:       evt_off = `URI_OFF_EV_CTS;
			1:       evt_off = `URI_OFF_EV_NCTS;
			2:       evt_off = `URI_OFF_EV_RXRDY;
			3:       evt_off = `URI_OFF_EV_TXRDY;
			4:       evt_off = `URI_OFF_EV_ERR;
			default: evt_off = `URI_OFF_EV_RECEIVER_TIMEOUT;
		endcase
	endfunction : evt_off

	// Plain configuration registers.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			enable_ff <= 4'h0;
			cfg_ff    <= '0;
			baud_ff   <= `URI_BAUD_RST;
			event_task_shortcuts_ff <= 2'h0;
			for (int i = 0; i < 4; i++) psel_ff[i] <= `URI_PSEL_RST;
		end else if (wr_in && hit) begin
			case (off)
				`URI_OFF_ENABLE: enable_ff <= wdata_in[3:0];
				`URI_OFF_CONFIG: cfg_ff <= wdata_in[4:0];
				`URI_OFF_BAUD:   baud_ff <= wdata_in;
				`URI_OFF_EVENT_TASK_SHORTCUTS: event_task_shortcuts_ff <= {wdata_in[`URI_SH_NCTS_BIT], wdata_in[`URI_SH_CTS_BIT]};
				`URI_OFF_PSEL0, `URI_OFF_PSEL1, `URI_OFF_PSEL2,
				`URI_OFF_PSEL3: psel_ff[off[3:2] - 2'h2] <= wdata_in;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a change is taken once stages two and three agree.
	logic [2:0] rxd_s_ff;                // Serial input chain.
	logic [2:0] cts_s_ff;                // Clear-to-send chain.
	logic       rxd_lvl_ff;              // Filtered serial input.
	logic       cts_lvl_ff;              // Filtered CTS, low is active.
	logic       cts_fall;                // CTS became active.
	logic       cts_rise;                // CTS became inactive.

	// Both chains idle high so no false edge appears out of reset.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rxd_s_ff   <= 3'h7;
			cts_s_ff   <= 3'h7;
			rxd_lvl_ff <= 1'b1;
			cts_lvl_ff <= 1'b1;
		end else begin
			rxd_s_ff <= {rxd_s_ff[1:0], rxd_in};
			cts_s_ff <= {cts_s_ff[1:0], cts_n_in};
			if (rxd_s_ff[1] == rxd_s_ff[2]) rxd_lvl_ff <= rxd_s_ff[2];
			if (cts_s_ff[1] == cts_s_ff[2]) cts_lvl_ff <= cts_s_ff[2];
		end
	end

	assign cts_fall = cts_lvl_ff && (cts_s_ff[1] == cts_s_ff[2]) && !cts_s_ff[2];
	assign cts_rise = !cts_lvl_ff && (cts_s_ff[1] == cts_s_ff[2]) && cts_s_ff[2];

	////////////////////////////////////////////////////////////////////////
	// Receiver enable, stop window and timeout.
	logic        rx_on_ff;               // Receiver accepting bytes.
	logic        rx_stop_ff;             // Stopped, still taking trailing bytes.
	logic [15:0] to_cyc_ff;              // Cycles within one bit time.
	logic [7:0]  to_bits_ff;             // Bit times since stop.
	logic        start_rx;
	logic        stop_rx;
	logic        receiver_timeout_done;

	// Processes, not assigns: trig reads the bus strobes, which must wake them.
	// start receiver
	always_comb start_rx = unit_on && (trig(`URI_OFF_START_RX) || (event_task_shortcuts_ff[0] && cts_fall));
	always_comb stop_rx = unit_on && (trig(`URI_OFF_STOP_RX) || trig(`URI_OFF_SUSPEND)
		|| (event_task_shortcuts_ff[1] && cts_rise));
	assign receiver_timeout_done = rx_stop_ff && (to_bits_ff == `URI_RECEIVER_TIMEOUT_BITS);

	// After a stop the receiver keeps sampling for a fixed number of bit
	// times so that bytes already in flight from the partner are kept.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || !unit_on) begin
			rx_on_ff   <= 1'b0;
			rx_stop_ff <= 1'b0;
			to_cyc_ff  <= 16'h0;
			to_bits_ff <= 8'h0;
		end else if (start_rx) begin
			rx_on_ff   <= 1'b1;
			rx_stop_ff <= 1'b0;
		end else if (stop_rx && rx_on_ff && !rx_stop_ff) begin
			rx_stop_ff <= 1'b1;
			to_cyc_ff  <= 16'h0;
			to_bits_ff <= 8'h0;
		end else if (receiver_timeout_done) begin
			rx_on_ff   <= 1'b0;
			rx_stop_ff <= 1'b0;
		end else if (rx_stop_ff) begin
			if (to_cyc_ff == div - 16'h1) begin
				to_cyc_ff  <= 16'h0;
				to_bits_ff <= to_bits_ff + 8'h1;
			end else begin
				to_cyc_ff <= to_cyc_ff + 16'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive shifter.
	uri_rx_st_t  rx_st_ff;
	logic [15:0] rx_cnt_ff;              // Cycles to next sample point.
	logic [2:0]  rx_bit_ff;              // Data bit index.
	logic [7:0]  rx_sh_ff;               // Shift register, LSB first.
	logic        rx_par_ff;              // Running even parity.
	logic        rx_push;                // Complete byte ready.
	logic        ovr_set;
	logic        par_set;
	logic        frm_set;
	logic        fifo_full;

	// Sample the start bit at its middle, then every bit period.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || !rx_on_ff) begin
			rx_st_ff  <= URI_RX_IDLE;
			rx_cnt_ff <= 16'h0;
			rx_bit_ff <= 3'h0;
			rx_sh_ff  <= 8'h0;
			rx_par_ff <= 1'b0;
		end else if (rx_st_ff == URI_RX_IDLE) begin
			if (!rxd_lvl_ff) begin
				rx_st_ff  <= URI_RX_START;
				rx_cnt_ff <= div >> 1;
			end
		end else if (rx_cnt_ff != 16'h0) begin
			rx_cnt_ff <= rx_cnt_ff - 16'h1;
		end else begin
			rx_cnt_ff <= div - 16'h1;
			case (rx_st_ff)
				// A glitch shorter than half a bit returns to idle.
				URI_RX_START: begin
					rx_st_ff  <= rxd_lvl_ff ? URI_RX_IDLE : URI_RX_DATA;
					rx_bit_ff <= 3'h0;
					rx_par_ff <= 1'b0;
				end
				URI_RX_DATA: begin
					rx_sh_ff  <= {rxd_lvl_ff, rx_sh_ff[7:1]};
					rx_par_ff <= rx_par_ff ^ rxd_lvl_ff;
					rx_bit_ff <= rx_bit_ff + 3'h1;
					if (rx_bit_ff == 3'h7) begin
						rx_st_ff <= (cfg_ff.parity == `URI_PARITY_ON) ? URI_RX_PAR : URI_RX_STOP;
					end
				end
				URI_RX_PAR:  rx_st_ff <= URI_RX_STOP;
				default:     rx_st_ff <= URI_RX_IDLE;
			endcase
		end
	end

	assign ovr_set = rx_on_ff && (rx_st_ff == URI_RX_IDLE) && !rxd_lvl_ff && fifo_full;
	assign par_set = (rx_st_ff == URI_RX_PAR) && (rx_cnt_ff == 16'h0) && (rx_par_ff != rxd_lvl_ff);
	assign frm_set = (rx_st_ff == URI_RX_STOP) && (rx_cnt_ff == 16'h0) && !rxd_lvl_ff;
	assign rx_push = (rx_st_ff == URI_RX_STOP) && (rx_cnt_ff == 16'h0) && rxd_lvl_ff;

	////////////////////////////////////////////////////////////////////////
	// Break detector.
	logic [19:0] brk_cnt_ff;             // Cycles the line has been low.
	logic [19:0] brk_lim;                // One frame in cycles, counted with one stop bit.
	logic        brk_set;

	assign brk_lim = ((cfg_ff.parity == `URI_PARITY_ON) ? `URI_FRAME_PAR : `URI_FRAME_NOPAR) * {4'h0, div};
	assign brk_set = (brk_cnt_ff == brk_lim);

	// Counting stops one past the limit, so a long break flags only once.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || !unit_on || rxd_lvl_ff) begin
			brk_cnt_ff <= 20'h0;
		end else if (brk_cnt_ff <= brk_lim) begin
			brk_cnt_ff <= brk_cnt_ff + 20'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive FIFO and holding register.
	logic [7:0]  fifo_mem [FIFO_DEPTH];  // Stored bytes.
	logic [PW-1:0] wp_ff;                // Write pointer.
	logic [PW-1:0] rp_ff;                // Read pointer.
	logic [PW:0]   cnt_ff;               // Bytes stored.
	logic [7:0]  hold_ff;                // Receive data register.
	logic        hold_v_ff;              // Holding register occupied.
	logic        pop;
	logic        rd_rxd;
	logic [PW-1:0] wp_last;

	assign fifo_full = (cnt_ff == DEPTH_C);
	assign pop       = !hold_v_ff && (cnt_ff != '0);
	assign rd_rxd    = rd_in && hit && (off == `URI_OFF_RXD);
	assign wp_last   = (wp_ff == '0) ? PW'(FIFO_DEPTH - 1) : wp_ff - PW'(1);

	// six-entry store
	// When full, a new byte overwrites the newest entry, keeping older ones.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (rx_push) begin
				if (fifo_full && !pop) begin
					fifo_mem[wp_last] <= rx_sh_ff;
				end else begin
					fifo_mem[wp_ff] <= rx_sh_ff;
					wp_ff <= (wp_ff == PW'(FIFO_DEPTH - 1)) ? '0 : wp_ff + PW'(1);
				end
			end
			if (pop) begin
				rp_ff <= (rp_ff == PW'(FIFO_DEPTH - 1)) ? '0 : rp_ff + PW'(1);
			end
			// A push beside a pop always takes a fresh place, so the count holds.
			if (pop && !rx_push) begin
				cnt_ff <= cnt_ff - (PW+1)'(1);
			end else if (rx_push && !pop && !fifo_full) begin
				cnt_ff <= cnt_ff + (PW+1)'(1);
			end
		end
	end

	// read clears, refill
	// The read empties the register; the next byte moves in a cycle later.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			hold_ff   <= 8'h0;
			hold_v_ff <= 1'b0;
		end else if (pop) begin
			// A pop only happens into an empty register, so it beats a read.
			hold_ff   <= fifo_mem[rp_ff];
			hold_v_ff <= 1'b1;
		end else if (rd_rxd) begin
			hold_ff   <= 8'h0;
			hold_v_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request-to-send with hysteresis: dropped at four free places,
	// raised again only once everything has been read out.
	logic rts_block_ff;

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rts_block_ff <= 1'b0;
		end else if (cnt_ff >= RTS_LVL) begin
			rts_block_ff <= 1'b1;
		end else if (cnt_ff == '0 && !hold_v_ff) begin
			rts_block_ff <= 1'b0;
		end
	end

	// Without flow control the line simply stays active while enabled.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			rts_n_out <= 1'b1;
		end else begin
			rts_n_out <= !(unit_on && (!cfg_ff.hw_flow_control_enable || (rx_on_ff && !rx_stop_ff && !rts_block_ff)));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter.
	uri_tx_st_t  tx_st_ff;
	logic        tx_on_ff;               // Transmitter started.
	logic        tx_pend_ff;             // Byte waiting in TXD.
	logic [7:0]  tx_buf_ff;              // Transmit data register.
	logic [7:0]  tx_sh_ff;               // Shift register.
	logic [15:0] tx_cnt_ff;              // Cycles left in this bit.
	logic [2:0]  tx_bit_ff;              // Data bit or stop bit index.
	logic        tx_par_ff;              // Running even parity.
	logic        stop_tx;
	logic        tx_go;
	logic        tx_done;

	always_comb stop_tx = trig(`URI_OFF_STOP_TX);
	// Flow control only holds back the next byte, never the one on the line.
	assign tx_go   = (tx_st_ff == URI_TX_IDLE) && tx_on_ff && tx_pend_ff && (!cfg_ff.hw_flow_control_enable || !cts_lvl_ff);
	assign tx_done = (tx_st_ff == URI_TX_STOP) && (tx_cnt_ff == 16'h0) && (tx_bit_ff[0] == cfg_ff.stop2);

	always_ff @(posedge ref_clk_in) begin
		if (srst_in || !unit_on) begin
			tx_on_ff <= 1'b0;
		end else if (trig(`URI_OFF_START_TX)) begin
			tx_on_ff <= 1'b1;
		end else if (stop_tx || trig(`URI_OFF_SUSPEND)) begin
			tx_on_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			tx_pend_ff <= 1'b0;
			tx_buf_ff  <= 8'h0;
		end else if (wr_in && hit && (off == `URI_OFF_TXD)) begin
			tx_pend_ff <= 1'b1;
			tx_buf_ff  <= wdata_in[7:0];
		end else if (tx_go) begin
			tx_pend_ff <= 1'b0;
		end
	end

	// Start bit, eight data bits LSB first, optional parity, stop bits.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || !unit_on || stop_tx) begin
			tx_st_ff  <= URI_TX_IDLE;
			tx_cnt_ff <= 16'h0;
			tx_bit_ff <= 3'h0;
			tx_sh_ff  <= 8'h0;
			tx_par_ff <= 1'b0;
			txd_out   <= 1'b1;
		end else if (tx_st_ff == URI_TX_IDLE) begin
			txd_out <= 1'b1;
			if (tx_go) begin
				tx_st_ff  <= URI_TX_START;
				tx_sh_ff  <= tx_buf_ff;
				tx_par_ff <= 1'b0;
				tx_cnt_ff <= div - 16'h1;
				txd_out   <= 1'b0;
			end
		end else if (tx_cnt_ff != 16'h0) begin
			tx_cnt_ff <= tx_cnt_ff - 16'h1;
		end else begin
			tx_cnt_ff <= div - 16'h1;
			case (tx_st_ff)
				URI_TX_START: begin
					tx_st_ff  <= URI_TX_DATA;
					tx_bit_ff <= 3'h0;
					txd_out   <= tx_sh_ff[0];
					tx_par_ff <= tx_sh_ff[0];
					tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
				end
				URI_TX_DATA: begin
					tx_bit_ff <= tx_bit_ff + 3'h1;
					if (tx_bit_ff == 3'h7) begin
						tx_bit_ff <= 3'h0;
						if (cfg_ff.parity == `URI_PARITY_ON) begin
							tx_st_ff <= URI_TX_PAR;
							txd_out  <= tx_par_ff;
						end else begin
							tx_st_ff <= URI_TX_STOP;
							txd_out  <= 1'b1;
						end
					end else begin
						txd_out   <= tx_sh_ff[0];
						tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
						tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
					end
				end
				URI_TX_PAR: begin
					tx_st_ff <= URI_TX_STOP;
					txd_out  <= 1'b1;
				end
				default: begin
					if (tx_done) tx_st_ff <= URI_TX_IDLE;
					tx_bit_ff <= tx_bit_ff + 3'h1;
					txd_out   <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Events, error sources and interrupt enables.
	uri_evt_t ev_set;
	uri_err_t er_set;

	assign er_set = '{brk: brk_set, framing: frm_set, parity: par_set, overrun: ovr_set};
	assign ev_set = '{receiver_timeout: receiver_timeout_done, err: |er_set, txrdy: tx_done, rxrdy: pop,
		ncts: cts_rise, cts: cts_fall};

	// sticky until zero written
	// A set in the clearing cycle wins, so no event is lost.
	generate
		for (genvar i = 0; i < 6; i++) begin : g_evt
			always_ff @(posedge ref_clk_in) begin
				if (srst_in) begin
					evt_ff[i] <= 1'b0;
				end else if (ev_set[i]) begin
					evt_ff[i] <= 1'b1;
				end else if (wr_in && hit && (off == evt_off(i)) && !wdata_in[0]) begin
					evt_ff[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			err_ff <= '0;
		end else if (wr_in && hit && (off == `URI_OFF_ERRSRC)) begin
			err_ff <= (err_ff & ~uri_err_t'(wdata_in[3:0])) | er_set;
		end else begin
			err_ff <= err_ff | er_set;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			inten_ff <= 6'h0;
		end else if (wr_in && hit && (off == `URI_OFF_IRQ_ENABLE_SET)) begin
			inten_ff <= inten_ff | ie_pack(wdata_in);
		end else if (wr_in && hit && (off == `URI_OFF_IRQ_ENABLE_CLEAR)) begin
			inten_ff <= inten_ff & ~ie_pack(wdata_in);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(evt_ff & inten_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port: data stand only in the cycle after the strobe; tasks,
	// TXD and unmapped offsets read as zero.
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || !(rd_in && hit)) begin
			rdata_out <= 32'h0;
		end else begin
			case (off)
				`URI_OFF_EV_CTS:   rdata_out <= {31'h0, evt_ff.cts};
				`URI_OFF_EV_NCTS:  rdata_out <= {31'h0, evt_ff.ncts};
				`URI_OFF_EV_RXRDY: rdata_out <= {31'h0, evt_ff.rxrdy};
				`URI_OFF_EV_TXRDY: rdata_out <= {31'h0, evt_ff.txrdy};
				`URI_OFF_EV_ERR:   rdata_out <= {31'h0, evt_ff.err};
				`URI_OFF_EV_RECEIVER_TIMEOUT:  rdata_out <= {31'h0, evt_ff.receiver_timeout};
				`URI_OFF_EVENT_TASK_SHORTCUTS:   rdata_out <= 32'(event_task_shortcuts_ff) << `URI_SH_CTS_BIT;
				`URI_OFF_IRQ_ENABLE_SET, `URI_OFF_IRQ_ENABLE_CLEAR: rdata_out <= ie_unpack(inten_ff);
				`URI_OFF_ERRSRC:   rdata_out <= {28'h0, err_ff};
				`URI_OFF_ENABLE:   rdata_out <= {28'h0, enable_ff};
				`URI_OFF_PSEL0, `URI_OFF_PSEL1, `URI_OFF_PSEL2,
				`URI_OFF_PSEL3: rdata_out <= psel_ff[off[3:2] - 2'h2];
				`URI_OFF_RXD:      rdata_out <= {24'h0, hold_ff};
				`URI_OFF_BAUD:     rdata_out <= baud_ff;
				`URI_OFF_CONFIG:   rdata_out <= {27'h0, cfg_ff};
				default:           rdata_out <= 32'h0;
			endcase
		end
	end

endmodule : uri_uart

// file: uri_uart_checker.sv
`timescale 1ns/10ps
module uri_uart_checker #(
	parameter int FIFO_DEPTH = 6
) (
	input wire logic        ref_clk_in,
	input wire logic        srst_in,
	input wire logic [31:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic        rxd_in,
	input wire logic        cts_n_in,
	input wire logic [31:0] rdata_out,
	input wire logic        txd_out,
	input wire logic        rts_n_out,
	input wire logic        irq_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in);
	property p_idle; !rd_in |=> rdata_out == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	property p_page; rd_in && addr_in[31:12] != 20'h40002 |=> rdata_out == 32'h0; endproperty
	a_page: assert property (p_page) else $error("foreign page answered");
	property p_task; rd_in && addr_in == 32'h40002000 |=> rdata_out == 32'h0; endproperty
	a_task: assert property (p_task) else $error("trigger read nonzero");
	property p_stop; wr_in && addr_in == 32'h4000200c && wdata_in[0] |-> ##2 txd_out; endproperty
	a_stop: assert property (p_stop) else $error("tx not aborted");
	property p_low; $fell(txd_out) |-> !txd_out [*8]; endproperty
	a_low: assert property (p_low) else $error("low bit too short");
	property p_high; $rose(txd_out) |-> txd_out [*8]; endproperty
	a_high: assert property (p_high) else $error("high bit too short");
	property p_irq; wr_in && addr_in == 32'h40002308 && wdata_in == 32'hffffffff |-> ##2 !irq_out; endproperty
	a_irq: assert property (p_irq) else $error("irq after disable");
	property p_ie; wr_in && addr_in == 32'h40002304 ##2 rd_in && addr_in == 32'h40002304
		|=> (rdata_out & $past(wdata_in, 3) & 32'h20287) == ($past(wdata_in, 3) & 32'h20287); endproperty
	a_ie: assert property (p_ie) else $error("enable not set");
endmodule : uri_uart_checker
bind uri_uart uri_uart_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rxd_in(rxd_in), .cts_n_in(cts_n_in),
	.rdata_out(rdata_out), .txd_out(txd_out), .rts_n_out(rts_n_out), .irq_out(irq_out));

// file: uri_uart_test.sv
`timescale 1ns/10ps
module uri_uart_test;
	logic        ref_clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic [31:0] addr_in = 32'h0;
	logic [31:0] wdata_in = 32'h0;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        ser_in;
	logic        cts_line;
	logic [31:0] rdata_out;
	logic        txd_out;
	logic        irq_out;
	logic        rts_n;
	logic [7:0]  rx_byte;
	int          error_cnt;
	int          n_checks;
	int          cyc;
	uri_uart dut_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rxd_in(ser_in), .cts_n_in(cts_line), .rdata_out(rdata_out),
		.txd_out(txd_out), .rts_n_out(rts_n), .irq_out(irq_out));
	uri_far_uart far_u (.ref_clk_in(ref_clk_in), .line_in(txd_out), .line_out(ser_in), .cts_n_out(cts_line));
	initial forever #2.5 ref_clk_in = ~ref_clk_in;
	task automatic end_sim;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim
	// Cuts a hang short well past the expected run length.
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		addr_in <= 32'h40002000 + a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge ref_clk_in) wr_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask : wr
	// Read data stands only in the cycle after the strobe.
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		addr_in <= 32'h40002000 + a;
		rd_in <= 1'b1;
		@(posedge ref_clk_in) rd_in <= 1'b0;
		@(negedge ref_clk_in) chk($sformatf("reg %h", a), rdata_out, e);
		@(posedge ref_clk_in);
	endtask : rd
	initial begin
		repeat (10) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		@(posedge ref_clk_in);
		rd(12'h000, 32'h0);
		rd(12'h524, 32'h6c8);
		rd(32'h1200, 32'h0);
		wr(12'h500, 32'h4);
		wr(12'h524, 32'h10);
		wr(12'h56c, 32'he);
		chk("rts", {31'h0, rts_n}, 32'h0);
		wr(12'h304, 32'hffffffff);
		rd(12'h304, 32'h20287);
		wr(12'h308, 32'h4);
		rd(12'h308, 32'h20283);
		wr(12'h200, 32'h8);
		far_u.cts_n_out <= 1'b0;
		repeat (9) @(posedge ref_clk_in);
		rd(12'h100, 32'h1);
		chk("irq", {31'h0, irq_out}, 32'h1);
		far_u.cts_n_out <= 1'b1;
		repeat (9) @(posedge ref_clk_in);
		rd(12'h104, 32'h1);
		wr(12'h100, 32'h0);
		rd(12'h100, 32'h0);
		far_u.send(8'ha5, 1'b0, 1'b0);
		far_u.send(8'h3c, 1'b1, 1'b0);
		repeat (9) @(posedge ref_clk_in);
		rd(12'h108, 32'h1);
		rd(12'h518, 32'ha5);
		repeat (2) @(posedge ref_clk_in);
		rd(12'h518, 32'h3c);
		rd(12'h480, 32'h2);
		rd(12'h124, 32'h1);
		far_u.send(8'h22, 1'b0, 1'b1);
		repeat (9) @(posedge ref_clk_in);
		rd(12'h480, 32'h6);
		wr(12'h480, 32'hf);
		for (int i = 0; i < 9; i++)
			far_u.send(8'h5a, 1'b0, 1'b0);
		rd(12'h480, 32'h1);
		wr(12'h004, 32'h1);
		repeat (820) @(posedge ref_clk_in);
		rd(12'h144, 32'h1);
		wr(12'h144, 32'h0);
		wr(12'h000, 32'h1);
		wr(12'h01c, 32'h1);
		repeat (820) @(posedge ref_clk_in);
		rd(12'h144, 32'h1);
		far_u.line_out <= 1'b0;
		repeat (200) @(posedge ref_clk_in);
		far_u.line_out <= 1'b1;
		repeat (9) @(posedge ref_clk_in);
		rd(12'h480, 32'h9);
		wr(12'h008, 32'h1);
		fork
			far_u.get(rx_byte);
			wr(12'h51c, 32'h5a);
		join
		chk("tx byte", {24'h0, rx_byte}, 32'h5a);
		repeat (60) @(posedge ref_clk_in);
		rd(12'h11c, 32'h1);
		wr(12'h51c, 32'h0);
		repeat (40) @(posedge ref_clk_in);
		wr(12'h00c, 32'h1);
		repeat (2) @(posedge ref_clk_in);
		chk("tx line", {31'h0, txd_out}, 32'h1);
		wr(12'h56c, 32'hf);
		repeat (2) @(posedge ref_clk_in);
		chk("rts", {31'h0, rts_n}, 32'h1);
		wr(12'h308, 32'hffffffff);
		repeat (2) @(posedge ref_clk_in);
		chk("irq", {31'h0, irq_out}, 32'h0);
		end_sim();
	end
endmodule : uri_uart_test
